// ===== fpes_cfg.svh
// Constants of the flash program and erase sequencer host
`ifndef FPES_CFG_SVH
`define FPES_CFG_SVH
`define FPES_CLK_MHZ 125
`define FPES_T_PHASE_NS 40
`define FPES_PHASE_CYC (((`FPES_T_PHASE_NS*`FPES_CLK_MHZ)+999)/1000)
`define FPES_T_RP_NS 500
`define FPES_RP_CYC (((`FPES_T_RP_NS*`FPES_CLK_MHZ)+999)/1000)
`define FPES_T_READY_NS 1000
`define FPES_READY_CYC (((`FPES_T_READY_NS*`FPES_CLK_MHZ)+999)/1000)
`define FPES_T_PROT_US 3
`define FPES_PROT_CYC ((`FPES_T_PROT_US*`FPES_CLK_MHZ))
`define FPES_T_SUSP_US 20
`define FPES_SUSP_CYC ((`FPES_T_SUSP_US*`FPES_CLK_MHZ))
`define FPES_T_HOLD_US 50
`define FPES_T_EGUARD_US 100
`define FPES_REG_CTRL 6'h00
`define FPES_REG_ADDR 6'h01
`define FPES_REG_DATA 6'h02
`define FPES_REG_STAT 6'h03
`define FPES_REG_RDATA 6'h04
`define FPES_AK_UNLK1 2'h0
`define FPES_AK_UNLK2 2'h1
`define FPES_AK_USER 2'h2
`define FPES_AK_DATA 2'h3
`define FPES_UNLK1_ADDR 21'h00_0555
`define FPES_UNLK2_ADDR 21'h00_02AA
`define FPES_C_UNLK1 8'hAA
`define FPES_C_UNLK2 8'h55
`define FPES_C_PROG 8'hA0
`define FPES_C_ESETUP 8'h80
`define FPES_C_CHIP 8'h10
`define FPES_C_BLOCK 8'h30
`define FPES_C_FAST 8'h20
`define FPES_C_FEXIT1 8'h90
`define FPES_C_FEXIT2 8'h00
`define FPES_C_SUSP 8'hB0
`define FPES_C_RESUME 8'h30
`define FPES_C_RESET 8'hF0
`endif

// ===== fpes_pkg.sv
// Types of the flash program and erase sequencer host
package fpes_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_PROG, OP_FAST_ENTER, OP_FAST_EXIT, OP_CHIP, OP_BLOCK,
    OP_SUSPEND, OP_RESUME, OP_RESET, OP_HWRST, OP_FPROG, OP_BADD
  } fpes_op_e;
  typedef enum logic [1:0] {K_NONE, K_PROG, K_CHIP, K_BLK} fpes_kind_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_SETUP, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RSTP,
    ST_PAUSE
  } fpes_st_e;
  typedef struct packed {
    fpes_st_e st;
    logic [2:0] step;
    logic [15:0] cnt;
    fpes_op_e op;
    logic [20:0] addr;
    logic [15:0] data;
    logic [15:0] rdata;
    logic fast;
    logic accel;
    logic susp;
    fpes_kind_e kind;
    logic [15:0] hold;
    logic [15:0] guard;
    logic refused;
    logic ack;
    logic [31:0] dat;
    logic [20:0] fa;
    logic [15:0] dq;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
  } fpes_state_s;
endpackage

// ===== fpes_seq_rom.sv
// Command sequence table with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "fpes_cfg.svh"
module fpes_seq_rom (
  input wire logic clk, // Core clock
  input wire fpes_pkg::fpes_op_e op, // Operation being sequenced
  input wire logic [2:0] step, // Bus write cycle index
  output logic [1:0] ak, // Address kind of this cycle
  output logic [7:0] code, // Command byte of this cycle
  output logic last // Final cycle of the sequence
);
  import fpes_pkg::*;
  logic [10:0] ent;
  // Table lookup: {address kind, command, last}
  always_comb begin
    case ({op, step})
      {OP_PROG, 3'h0}, {OP_FAST_ENTER, 3'h0}, {OP_CHIP, 3'h0},
      {OP_BLOCK, 3'h0}, {OP_CHIP, 3'h3}, {OP_BLOCK, 3'h3}: begin
        ent = {`FPES_AK_UNLK1, `FPES_C_UNLK1, 1'b0};
      end
      {OP_PROG, 3'h1}, {OP_FAST_ENTER, 3'h1}, {OP_CHIP, 3'h1},
      {OP_BLOCK, 3'h1}, {OP_CHIP, 3'h4}, {OP_BLOCK, 3'h4}: begin
        ent = {`FPES_AK_UNLK2, `FPES_C_UNLK2, 1'b0};
      end
      {OP_PROG, 3'h2}: ent = {`FPES_AK_UNLK1, `FPES_C_PROG, 1'b0};
      {OP_PROG, 3'h3}: ent = {`FPES_AK_DATA, 8'h00, 1'b1};
      {OP_FPROG, 3'h0}: ent = {`FPES_AK_USER, `FPES_C_PROG, 1'b0};
      {OP_FPROG, 3'h1}: ent = {`FPES_AK_DATA, 8'h00, 1'b1};
      {OP_FAST_ENTER, 3'h2}: ent = {`FPES_AK_UNLK1, `FPES_C_FAST, 1'b1};
      {OP_FAST_EXIT, 3'h0}: ent = {`FPES_AK_USER, `FPES_C_FEXIT1, 1'b0};
      {OP_FAST_EXIT, 3'h1}: ent = {`FPES_AK_USER, `FPES_C_FEXIT2, 1'b1};
      {OP_CHIP, 3'h2}, {OP_BLOCK, 3'h2}: begin
        ent = {`FPES_AK_UNLK1, `FPES_C_ESETUP, 1'b0};
      end
      {OP_CHIP, 3'h5}: ent = {`FPES_AK_UNLK1, `FPES_C_CHIP, 1'b1};
      {OP_BLOCK, 3'h5}, {OP_BADD, 3'h0}: begin
        ent = {`FPES_AK_USER, `FPES_C_BLOCK, 1'b1};
      end
      {OP_SUSPEND, 3'h0}: ent = {`FPES_AK_USER, `FPES_C_SUSP, 1'b1};
      {OP_RESUME, 3'h0}: ent = {`FPES_AK_USER, `FPES_C_RESUME, 1'b1};
      default: ent = {`FPES_AK_USER, `FPES_C_RESET, 1'b1};
    endcase
  end
  // Registered read port
  always_ff @(posedge clk) begin
    {ak, code, last} <= ent;
  end
endmodule // fpes_seq_rom
`default_nettype wire

// ===== fpes_host.sv
// Host controller that drives flash program and erase command sequences
//
// Contract
// - Address set before write strobe falls; data held until strobe rises.
// - Only a hardware reset pulse aborts a running program.
// - Program failure keeps device busy; reset command or pulse recovers it.
// - Fast or accelerated program uses two bus write cycles.
// - Fast mode lasts until the fast exit sequence is sent.
// - Resume only from suspend, naming the bank being written.
// - Acceleration voltage must stay applied while program is suspended.
// - No commands during chip erase; after reset-abort erase again. The host still sends the reset command during chip erase.
// - Erase failure keeps device busy; reset command or pulse recovers it.
// - Only further block addresses may follow within the hold window.
// - Command data sits in the low byte; upper byte driven zero.
`timescale 1ns/1ps
`default_nettype none
`include "fpes_cfg.svh"
module fpes_host #(
  parameter logic [15:0] HOLD_CYC = 16'(`FPES_T_HOLD_US*`FPES_CLK_MHZ),
  parameter logic [15:0] EGUARD_CYC = 16'(`FPES_T_EGUARD_US*`FPES_CLK_MHZ)
) (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST, // Synchronous reset, high
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Bus strobe
  input wire logic WB_WE_I, // Bus write
  input wire logic [7:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte lanes
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  output logic [20:0] FLASH_ADDR, // Flash address
  input wire logic [15:0] FLASH_DQ_I, // Flash data in
  output logic [15:0] FLASH_DQ_O, // Flash data out
  output logic FLASH_DQ_OE, // Data drive enable
  output logic FLASH_SELECT_N, // Flash select
  output logic FLASH_WE_N, // Write strobe
  output logic FLASH_OE_N, // Output enable
  output logic FLASH_RESET_N, // Hardware reset
  input wire logic FLASH_READY, // Ready high, busy low
  output logic ACCEL_VOLTAGE_LEVEL // Apply accel voltage on protect pin
);
  import fpes_pkg::*;

  fpes_state_s s_q;
  fpes_state_s s_d;
  logic [1:0] rom_ak;
  logic [7:0] rom_code;
  logic rom_last;
  logic [5:0] idx;
  logic wr;
  logic rd_req;
  fpes_op_e req_op;
  fpes_op_e eop;
  logic [31:0] addr_mrg; // Address register with write lanes merged
  logic [31:0] data_mrg; // Data register with write lanes merged

  // Merge write data into a register by byte lane
  function automatic logic [31:0] lane(input logic [31:0] o,
                                       input logic [31:0] w,
                                       input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Whether an operation may be launched in the present device state
  function automatic logic op_ok(input fpes_op_e op, input fpes_kind_e k,
                                 input logic hold_open, input logic fast,
                                 input logic susp);
    logic r;
    r = 1'b0;
    if (hold_open) begin
      r = (op == OP_BADD) || (op == OP_HWRST) || (op == OP_READ);
    end else begin
      case (op)
        OP_READ, OP_RESET, OP_HWRST: r = 1'b1;
        OP_PROG, OP_FPROG, OP_CHIP, OP_BLOCK, OP_FAST_ENTER: begin
          r = (k == K_NONE) && !susp;
        end
        OP_FAST_EXIT: r = fast && (k == K_NONE) && !susp;
        OP_SUSPEND: r = (k == K_PROG) && !susp;
        OP_RESUME: r = susp;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  fpes_seq_rom u_rom (
    .clk(CORE_CLK),
    .op(s_q.op),
    .step(s_q.step),
    .ak(rom_ak),
    .code(rom_code),
    .last(rom_last)
  );

  // Bus request decode and effective operation
  always_comb begin
    idx = WB_ADR_I[7:2];
    rd_req = WB_CYC_I && WB_STB_I && !s_q.ack;
    wr = rd_req && WB_WE_I;
    addr_mrg = lane({11'h000, s_q.addr}, WB_DAT_I, WB_SEL_I);
    data_mrg = lane({16'h0000, s_q.data}, WB_DAT_I, WB_SEL_I);
    req_op = fpes_op_e'(WB_DAT_I[3:0]);
    eop = req_op;
    if (req_op == OP_PROG && (s_q.fast || s_q.accel)) begin
      eop = OP_FPROG;
    end else if (req_op == OP_BLOCK && s_q.hold != 16'h0000) begin
      eop = OP_BADD;
    end
  end

  // Next state of the whole controller
  always_comb begin
    s_d = s_q;
    s_d.ack = rd_req;
    if (s_q.hold != 16'h0000) begin
      s_d.hold = s_q.hold - 16'h0001;
    end
    if (s_q.guard != 16'h0000) begin
      s_d.guard = s_q.guard - 16'h0001;
    end
    // Busy bank is taken as done only after the guard and ready pin agree
    if (s_q.st == ST_IDLE && s_q.guard == 16'h0000 &&
        s_q.hold == 16'h0000 && !s_q.susp && FLASH_READY) begin
      s_d.kind = K_NONE;
    end
    // Register reads
    if (rd_req && !WB_WE_I) begin
      case (idx)
        `FPES_REG_CTRL: s_d.dat = {23'h00_0000, s_q.accel, 8'h00};
        `FPES_REG_ADDR: s_d.dat = {11'h000, s_q.addr};
        `FPES_REG_DATA: s_d.dat = {16'h0000, s_q.data};
        `FPES_REG_STAT: begin
          s_d.dat = {22'h00_0000, FLASH_READY, s_q.st != ST_IDLE,
                     s_q.hold != 16'h0000, s_q.susp, s_q.accel, s_q.fast,
                     s_q.kind, 1'b0, s_q.refused};
        end
        `FPES_REG_RDATA: s_d.dat = {16'h0000, s_q.rdata};
        default: s_d.dat = 32'h0000_0000;
      endcase
    end
    // Register writes
    if (wr && idx == `FPES_REG_ADDR) begin
      s_d.addr = addr_mrg[20:0];
    end
    if (wr && idx == `FPES_REG_DATA) begin
      s_d.data = data_mrg[15:0];
    end
    if (wr && idx == `FPES_REG_STAT && WB_SEL_I[0] && WB_DAT_I[0]) begin
      s_d.refused = 1'b0;
    end
    if (wr && idx == `FPES_REG_CTRL && WB_SEL_I[1] && !s_q.susp) begin
      s_d.accel = WB_DAT_I[8];
    end
    // Launch an operation, or flag it as refused (set wins over clear)
    if (wr && idx == `FPES_REG_CTRL && WB_SEL_I[0]) begin
      if (s_q.st == ST_IDLE && WB_DAT_I[3:0] <= 4'(OP_HWRST) &&
          op_ok(eop, s_q.kind, s_q.hold != 16'h0000, s_q.fast,
                s_q.susp)) begin
        s_d.op = eop;
        s_d.step = 3'h0;
        if (eop == OP_READ) begin
          s_d.st = ST_RLOW;
          s_d.fa = s_q.addr;
          s_d.ce_n = 1'b0;
          s_d.oe_n = 1'b0;
          s_d.cnt = 16'(`FPES_PHASE_CYC);
        end else if (eop == OP_HWRST) begin
          s_d.st = ST_RSTP;
          s_d.rst_n = 1'b0;
          s_d.cnt = 16'(`FPES_RP_CYC);
        end else begin
          s_d.st = ST_FETCH;
          s_d.cnt = 16'h0001;
        end
      end else begin
        s_d.refused = 1'b1;
      end
    end
    // Pin sequencing
    case (s_q.st)
      ST_IDLE: begin
        s_d.dq_oe = 1'b0;
      end
      ST_FETCH: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          // Address and data settle before the strobe falls
          s_d.st = ST_SETUP;
          s_d.ce_n = 1'b0;
          s_d.dq_oe = 1'b1;
          s_d.cnt = 16'(`FPES_PHASE_CYC);
          case (rom_ak)
            `FPES_AK_UNLK1: s_d.fa = `FPES_UNLK1_ADDR;
            `FPES_AK_UNLK2: s_d.fa = `FPES_UNLK2_ADDR;
            default: s_d.fa = s_q.addr;
          endcase
          // Command bytes go on the low lane only; program data whole
          s_d.dq = (rom_ak == `FPES_AK_DATA) ? s_q.data :
                   {8'h00, rom_code};
        end
      end
      ST_SETUP: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.st = ST_WLOW;
          s_d.we_n = 1'b0;
          s_d.cnt = 16'(`FPES_PHASE_CYC);
        end
      end
      ST_WLOW: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.st = ST_WHIGH;
          s_d.we_n = 1'b1;
          s_d.cnt = 16'(`FPES_PHASE_CYC);
          if (rom_last) begin
            case (s_q.op)
              OP_PROG, OP_FPROG: begin
                s_d.kind = K_PROG;
                s_d.guard = 16'(`FPES_PROT_CYC);
              end
              OP_CHIP: begin
                s_d.kind = K_CHIP;
                s_d.guard = EGUARD_CYC;
              end
              OP_BLOCK, OP_BADD: begin
                s_d.kind = K_BLK;
                s_d.hold = HOLD_CYC;
                s_d.guard = EGUARD_CYC;
              end
              OP_FAST_ENTER: s_d.fast = 1'b1;
              OP_FAST_EXIT: s_d.fast = 1'b0;
              OP_SUSPEND: s_d.susp = 1'b1;
              OP_RESUME: begin
                s_d.susp = 1'b0;
                s_d.guard = 16'(`FPES_PROT_CYC);
              end
              default: begin
                // Busy kind stays until the ready pin says the work ended
                s_d.hold = 16'h0000;
              end
            endcase
          end
        end
      end
      ST_WHIGH: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.ce_n = 1'b1;
          s_d.dq_oe = 1'b0;
          s_d.step = s_q.step + 3'h1;
          if (!rom_last) begin
            s_d.st = ST_FETCH;
            s_d.cnt = 16'h0001;
          end else if (s_q.op == OP_SUSPEND) begin
            s_d.st = ST_PAUSE;
            s_d.cnt = 16'(`FPES_SUSP_CYC);
          end else begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_RLOW: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.rdata = FLASH_DQ_I;
          s_d.oe_n = 1'b1;
          s_d.ce_n = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      ST_RSTP: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.rst_n = 1'b1;
          s_d.fast = 1'b0;
          s_d.susp = 1'b0;
          s_d.kind = K_NONE;
          s_d.hold = 16'h0000;
          s_d.guard = 16'h0000;
          s_d.st = ST_PAUSE;
          s_d.cnt = 16'(`FPES_READY_CYC);
        end
      end
      ST_PAUSE: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.ce_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.rst_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Output ports
  assign WB_DAT_O = s_q.dat;
  assign WB_ACK_O = s_q.ack;
  assign FLASH_ADDR = s_q.fa;
  assign FLASH_DQ_O = s_q.dq;
  assign FLASH_DQ_OE = s_q.dq_oe;
  assign FLASH_SELECT_N = s_q.ce_n;
  assign FLASH_WE_N = s_q.we_n;
  assign FLASH_OE_N = s_q.oe_n;
  assign FLASH_RESET_N = s_q.rst_n;
  assign ACCEL_VOLTAGE_LEVEL = s_q.accel;

  // Checks on pin and bus behaviour
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  a_ack_answer: assert property (rd_req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single pulse after request");
  a_data_at_rise: assert property ($rose(FLASH_WE_N) |->
    $past(FLASH_DQ_OE) && $stable(FLASH_DQ_O) && !FLASH_SELECT_N)
    else $error("data not held at write strobe rise");
  a_addr_stable: assert property (!FLASH_WE_N |=>
    $stable(FLASH_ADDR) || FLASH_WE_N)
    else $error("address moved while write strobe low");
  a_we_pulse: assert property ($fell(FLASH_WE_N) |->
    (!FLASH_WE_N)[*6] ##1 FLASH_WE_N)
    else $error("write strobe low width wrong");
  a_reset_width: assert property ($fell(FLASH_RESET_N) |->
    (!FLASH_RESET_N)[*8])
    else $error("hardware reset pulse too short");
  a_no_contend: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE)
    else $error("driving data while flash outputs");
  a_accel_held: assert property (s_q.susp && $past(s_q.susp) |->
    $stable(ACCEL_VOLTAGE_LEVEL))
    else $error("accel voltage changed while suspended");
  a_busy_refuse: assert property (wr && idx == `FPES_REG_CTRL &&
    WB_SEL_I[0] && req_op == OP_PROG && s_q.kind != K_NONE |=>
    s_q.refused && s_q.st == ST_IDLE)
    else $error("program launched while bank busy");
  a_hold_only: assert property (s_q.hold != 16'h0000 && wr &&
    idx == `FPES_REG_CTRL && WB_SEL_I[0] && req_op == OP_CHIP |=>
    s_q.refused)
    else $error("command other than block accepted in hold window");
  a_rst_cmdfree: assert property (!FLASH_RESET_N |-> FLASH_WE_N)
    else $error("write strobe during hardware reset");

  c_prog_done: cover property (s_q.kind == K_PROG ##1 s_q.kind == K_NONE);
  c_multi_blk: cover property (s_q.op == OP_BADD && $rose(FLASH_WE_N));
  c_suspend: cover property ($rose(s_q.susp));
  c_chip: cover property ($rose(s_q.kind == K_CHIP));
endmodule // fpes_host
`default_nettype wire

// ===== fpes_flash_model.sv
// Behavioural flash device facing the sequencer host
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model #(
  parameter int PROG_T = 400, // Program busy clocks
  parameter int ERASE_T = 200, // Erase busy clocks
  parameter int HOLD_T = 60 // Erase hold window clocks
) (
  input wire logic clk, // Timing reference
  input wire logic [20:0] addr, // Address pins
  input wire logic [15:0] dq_in, // Data from host
  input wire logic sel_n, // Flash select
  input wire logic we_n, // Write strobe
  input wire logic oe_n, // Output enable
  input wire logic rst_n, // Hardware reset
  input wire logic accel, // Accel voltage present
  output logic [15:0] dq_out, // Data to host
  output logic ready // Ready high
);
  logic [15:0] mem [256];
  logic [15:0] blk, tgl;
  logic [20:0] a_q;
  logic [7:0] c;
  logic [2:0] p;
  logic fast, fail, susp, pr;
  int busy, hold;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {tgl, p, fast, fail, susp, pr, blk, busy, hold} = '0;
  end
  // Address taken as the strobe falls
  always @(negedge we_n) if (!sel_n) a_q = addr;
  // Command decode as the strobe rises, low byte only
  always @(posedge we_n) if (!sel_n && rst_n) begin
    c = dq_in[7:0];
    if (fail) begin
      if (c == 8'hF0) {fail, busy, hold, blk} = '0;
    end else if (hold > 0) begin
      if (c == 8'h30) begin
        blk[a_q[7:4]] = 1'b1;
        hold = HOLD_T;
      end else {hold, blk} = '0;
    end else if (busy > 0) begin
      if (pr && c == 8'hB0) susp = 1'b1;
      else if (pr && susp && c == 8'h30) susp = 1'b0;
    end else begin
      case (p)
        3'd0: if (c == 8'hAA) p = 3'd1;
          else if (c == 8'hA0 && (fast || accel)) p = 3'd3;
          else if (c == 8'h90 && fast) p = 3'd5;
        3'd1: p = (c == 8'h55) ? 3'd2 : 3'd0;
        3'd2: begin
          fast = fast || (c == 8'h20);
          p = (c == 8'hA0) ? 3'd3 : (c == 8'h80) ? 3'd4 : 3'd0;
        end
        3'd3: begin
          fail = |(dq_in & ~mem[a_q[7:0]]);
          mem[a_q[7:0]] = mem[a_q[7:0]] & dq_in;
          {pr, busy, p} = {1'b1, PROG_T, 3'd0};
        end
        3'd4: p = (c == 8'hAA) ? 3'd6 : 3'd0;
        3'd6: p = (c == 8'h55) ? 3'd7 : 3'd0;
        3'd7: begin
          pr = 1'b0;
          if (c == 8'h10) {blk, busy} = {16'hFFFF, ERASE_T};
          if (c == 8'h30) blk[a_q[7:4]] = 1'b1;
          hold = (c == 8'h30) ? HOLD_T : 0;
          p = 3'd0;
        end
        default: begin
          fast = fast && (c != 8'h00);
          p = 3'd0;
        end
      endcase
    end
  end
  // Timing off the host's sampling edge; reset aborts and spoils data
  always @(negedge clk) begin
    tgl = tgl + 16'h3C5B;
    if (!rst_n) begin
      if (busy > 0 && pr) mem[a_q[7:0]] = ~mem[a_q[7:0]];
      {p, fast, fail, susp, pr, blk, busy, hold} = '0;
    end else if (hold > 0) begin
      hold = hold - 1;
      if (hold == 0) busy = ERASE_T;
    end else if (busy > 0 && !susp && !fail) begin
      busy = busy - 1;
      if (busy == 0) begin
        foreach (mem[i]) if (blk[i[7:4]]) mem[i] = 16'hFFFF;
        blk = '0;
      end
    end
  end
  assign ready = rst_n && !fail && hold == 0 && (busy == 0 || susp);
  // Array data when readable, a moving pattern otherwise
  assign dq_out = (!sel_n && !oe_n && (busy == 0 || susp)) ?
    mem[addr[7:0]] : tgl;
endmodule // fpes_flash_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the sequencer host with a flash model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, cyc, stb, we, ack, dq_oe, sel_n, we_n, oe_n, frst_n, rdy, acc;
  logic [7:0] adr, a;
  logic [3:0] sel;
  logic [31:0] wd, rd_d, rv;
  logic [20:0] fa;
  logic [15:0] dqo, dqi;
  logic [15:0] em [256];
  int n_errors, n_checks, nwe, nrs, ncyc, seed, i;
  fpes_host #(.HOLD_CYC(16'h0028), .EGUARD_CYC(16'h003C)) dut (
    .CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
    .WB_DAT_O(rd_d), .WB_ACK_O(ack), .FLASH_ADDR(fa), .FLASH_DQ_I(dqi),
    .FLASH_DQ_O(dqo), .FLASH_DQ_OE(dq_oe), .FLASH_SELECT_N(sel_n),
    .FLASH_WE_N(we_n), .FLASH_OE_N(oe_n), .FLASH_RESET_N(frst_n),
    .FLASH_READY(rdy), .ACCEL_VOLTAGE_LEVEL(acc));
  fpes_flash_model flash (.clk(clk), .addr(fa), .dq_in(dqo), .sel_n(sel_n),
    .we_n(we_n), .oe_n(oe_n), .rst_n(frst_n), .accel(acc), .dq_out(dqi),
    .ready(rdy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Strobe and reset-pulse counters, and the hang limit
  always @(negedge we_n) nwe++;
  always @(posedge clk) begin
    ncyc++;
    if (frst_n === 1'b0) nrs++;
    if (ncyc > 60000) begin
      n_errors++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] o, d);
    return o & d;
  endfunction
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wd <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rv = rd_d;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wa(input logic [7:0] x);
    wb(1'b1, 8'h04, {24'h0, x}, 4'hF);
  endtask
  task automatic clr;
    wb(1'b1, 8'h0C, 32'h1, 4'h1);
  endtask
  task automatic idle(input logic k);
    do wb(1'b0, 8'h0C, 32'h0, 4'h0);
    while (rv[8] || (k && rv[3:2] != 2'd0));
  endtask
  task automatic op(input logic [3:0] o, input logic k);
    nwe = 0;
    wb(1'b1, 8'h00, {28'h0, o}, 4'h1);
    idle(k);
  endtask
  task automatic prog(input logic [7:0] x, input logic [15:0] d,
                      input logic k);
    wa(x);
    wb(1'b1, 8'h08, {16'h0, d}, 4'hF);
    op(4'h1, k);
    em[x] = nxt(em[x], d);
  endtask
  task automatic rdf(input logic [7:0] x);
    wa(x);
    op(4'h0, 1'b0);
    wb(1'b0, 8'h10, 32'h0, 4'h0);
  endtask
  initial begin
    seed = 23;
    {rst, cyc, stb, we, adr, sel, wd} = {1'b1, 47'h0};
    foreach (em[j]) em[j] = 16'hFFFF;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset state, unmapped place, refused orders
    wb(1'b0, 8'h0C, 32'h0, 4'h0);
    chk(rv, 32'h0000_0200);
    wb(1'b0, 8'h3C, 32'h0, 4'h0);
    chk(rv, 32'h0);
    op(4'h6, 1'b1);
    chk(rv[0], 1'b1);
    clr;
    op(4'hC, 1'b1);
    chk(rv[0], 1'b1);
    clr;
    $display("done: reset");
    // Random words into erased cells, read back
    for (i = 0; i < 4; i++) begin
      a = {i[3:0], 4'($random(seed))};
      prog(a, 16'($random(seed)), 1'b1);
      chk(nwe, 4);
      rdf(a);
      chk(rv, {16'h0, em[a]});
    end
    $display("done: program");
    // Setting a cleared bit fails and locks until a reset order
    prog(8'hF0, 16'h0000, 1'b1);
    prog(8'hF0, 16'h00FF, 1'b0);
    chk(rv[9], 1'b0);
    chk(rv[3:2], 2'd1);
    op(4'h8, 1'b1);
    chk(rv[9], 1'b1);
    $display("done: failure");
    // A program order while a program runs reaches no pin
    prog(8'h91, 16'h1248, 1'b0);
    op(4'h1, 1'b0);
    chk(nwe, 0);
    chk(rv[0], 1'b1);
    clr;
    idle(1'b1);
    $display("done: busy refusal");
    // Fast mode until its exit sequence
    op(4'h2, 1'b1);
    chk(nwe, 3);
    prog(8'h52, 16'($random(seed)), 1'b1);
    chk(nwe, 2);
    rdf(8'h52);
    chk(rv, {16'h0, em[8'h52]});
    op(4'h3, 1'b1);
    chk(nwe, 2);
    prog(8'h53, 16'h0F0F, 1'b1);
    chk(nwe, 4);
    $display("done: fast");
    // Accel voltage held through suspend, read and resume
    wb(1'b1, 8'h00, 32'h0000_0100, 4'h2);
    chk(acc, 1'b1);
    prog(8'h64, 16'h00C3, 1'b0);
    chk(nwe, 2);
    op(4'h6, 1'b0);
    chk(rv[6], 1'b1);
    wb(1'b1, 8'h00, 32'h0, 4'h2);
    chk(acc, 1'b1);
    rdf(8'h60);
    chk(rv, {16'h0, em[8'h60]});
    op(4'h7, 1'b1);
    chk(nwe, 1);
    rdf(8'h64);
    chk(rv, {16'h0, em[8'h64]});
    wb(1'b1, 8'h00, 32'h0, 4'h2);
    $display("done: suspend");
    // Chip erase; a reset order meanwhile is ignored
    op(4'h4, 1'b0);
    chk(nwe, 6);
    op(4'h8, 1'b1);
    foreach (em[j]) em[j] = 16'hFFFF;
    rdf(8'h64);
    chk(rv, {16'h0, em[8'h64]});
    $display("done: chip erase");
    // Two blocks in one hold window, a chip erase refused there
    prog(8'h25, 16'h1234, 1'b1);
    prog(8'h48, 16'h4321, 1'b1);
    wa(8'h30);
    op(4'h5, 1'b0);
    chk(nwe, 6);
    chk(rv[7], 1'b1);
    wa(8'h20);
    op(4'h5, 1'b0);
    chk(nwe, 1);
    op(4'h4, 1'b0);
    chk(nwe, 0);
    chk(rv[0], 1'b1);
    clr;
    idle(1'b1);
    for (i = 8'h20; i < 8'h40; i++) em[i] = 16'hFFFF;
    rdf(8'h25);
    chk(rv, {16'h0, em[8'h25]});
    rdf(8'h48);
    chk(rv, {16'h0, em[8'h48]});
    $display("done: block erase");
    // Hardware reset aborts a running program
    prog(8'h70, 16'h00FF, 1'b0);
    nrs = 0;
    op(4'h9, 1'b1);
    chk(nrs, 64);
    chk(flash.busy, 0);
    $display("done: hardware reset");
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
